// file: hdl/low_volt_monitor.sv
// Low-voltage live status and sticky error flag.
// Assumes low_volt_sense is synchronous to ref_clk.
`timescale 1ns/100ps
`include "nvm_defs.svh"

module low_volt_monitor (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic detector_on,
    input  wire logic low_volt_sense,
    input  wire logic in_operation,
    input  wire logic clear_flags,
    output logic      low_volt_live,
    output logic      low_volt_error
);
    logic event_now;

    assign event_now = detector_on && low_volt_sense;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_volt_live <= 1'b0;
        end else begin
            low_volt_live <= event_now;
        end
    end

    // Set wins over the clear from a no-op start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_volt_error <= 1'b0;
        end else if (event_now && in_operation) begin
            low_volt_error <= 1'b1;
        end else if (clear_flags) begin
            low_volt_error <= 1'b0;
        end
    end
endmodule : low_volt_monitor

// file: hdl/nvm_defs.svh
// Constants for the program memory control block.
// Assumes word-addressed register port with byte offsets.
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

`define ADDR_W          8
`define OFS_CONTROL     8'h00
`define OFS_UNLOCK_KEY  8'h04
`define OFS_TARGET      8'h08

`define BIT_GO          15
`define BIT_ARM         14
`define BIT_FAIL        13
`define BIT_LV_ERR      12
`define BIT_LV_LIVE     11
`define OP_HI           3
`define OP_LO           0

`define OP_NOP0         4'h0
`define OP_NOP2         4'h2
`define OP_ROW_PROG     4'h3
`define OP_PAGE_ERASE   4'h4
`define OP_ARRAY_ERASE  4'h5
`define OP_NOP6         4'h6

// Arbitrary unlock key values
`define UNLOCK_KEY_A    32'h5A5A1234
`define UNLOCK_KEY_B    32'hC3C30F0F

`define ZERO32          32'h00000000
`define ZERO4           4'h0

`endif

// file: hdl/nvm_pkg.sv
// Types shared by the program memory control block.
// Assumes nvm_defs.svh is available on the include path.
package nvm_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_LAUNCH,
        SEQ_WAIT
    } seq_state_e;

    typedef struct packed {
        logic        start;
        logic [3:0]  op;
        logic [31:0] addr;
    } array_cmd_s;

    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [7:0]           addr;
        logic [31:0]          wdata;
    } reg_req_s;

endpackage : nvm_pkg

// file: hdl/nvm_program_control.sv
// Program memory control: control register, unlock, operation sequencer.
// Assumes a memory array that answers array_cmd.start with one array_done pulse.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "nvm_defs.svh"

module nvm_program_control (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                device_reset,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    output nvm_pkg::array_cmd_s      array_cmd,
    input  wire logic                array_done,
    input  wire logic                array_fail,
    input  wire logic                page_protected,
    input  wire logic                any_protected,
    input  wire logic                low_volt_sense,
    output logic                     detector_on
);
    nvm_pkg::reg_req_s   req;
    nvm_pkg::seq_state_e state_reg;
    logic                arm_reg;
    logic                go_reg;
    logic                fail_reg;
    logic [3:0]          op_reg;
    logic [31:0]         target_reg;
    logic                unlocked;
    logic                low_volt_live;
    logic                low_volt_error;
    logic                ctl_wr;
    logic                key_wr;
    logic                go_accept;
    logic                clear_flags;
    logic                op_is_nop;
    logic                op_is_real;
    logic                op_blocked;
    logic [31:0]         ctl_view;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    always_comb begin
        ctl_wr = 1'b0;
        key_wr = 1'b0;
        if (req.wr && req.addr == `OFS_CONTROL) begin
            ctl_wr = 1'b1;
        end else if (req.wr && req.addr == `OFS_UNLOCK_KEY) begin
            key_wr = 1'b1;
        end
    end

    unlock_detector u_unlock (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .key_wr   (key_wr),
        .key_data (req.wdata),
        .other_wr (req.wr && !key_wr),
        .unlocked (unlocked)
    );

    assign go_accept = ctl_wr && req.wdata[`BIT_GO] && arm_reg && unlocked
                       && !go_reg;
    assign detector_on = arm_reg;

    assign op_is_nop  = (op_reg == `OP_NOP0) || (op_reg == `OP_NOP2)
                        || (op_reg == `OP_NOP6);
    assign op_is_real = (op_reg == `OP_ROW_PROG) || (op_reg == `OP_PAGE_ERASE)
                        || (op_reg == `OP_ARRAY_ERASE);
    assign op_blocked = (op_reg == `OP_ARRAY_ERASE) ? any_protected
                                                    : page_protected;
    assign clear_flags = (state_reg == nvm_pkg::SEQ_LAUNCH)
                         && (op_reg == `OP_NOP0);

    low_volt_monitor u_lv (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .detector_on    (arm_reg),
        .low_volt_sense (low_volt_sense),
        .in_operation   (go_reg),
        .clear_flags    (clear_flags),
        .low_volt_live  (low_volt_live),
        .low_volt_error (low_volt_error)
    );

    // Arm bit: the only control bit a device reset touches
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arm_reg <= 1'b0;
        end else if (device_reset) begin
            arm_reg <= 1'b0;
        end else if (ctl_wr) begin
            arm_reg <= req.wdata[`BIT_ARM];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_reg <= `ZERO4;
        end else if (ctl_wr && !arm_reg) begin
            op_reg <= req.wdata[`OP_HI:`OP_LO];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            target_reg <= `ZERO32;
        end else if (req.wr && req.addr == `OFS_TARGET && !go_reg) begin
            target_reg <= req.wdata;
        end
    end

    // Sequencer: go stays high from acceptance until the operation ends
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= nvm_pkg::SEQ_IDLE;
            go_reg    <= 1'b0;
            array_cmd <= '0;
        end else begin
            array_cmd.start <= 1'b0;
            case (state_reg)
                nvm_pkg::SEQ_IDLE: begin
                    if (go_accept) begin
                        go_reg    <= 1'b1;
                        state_reg <= nvm_pkg::SEQ_LAUNCH;
                    end
                end
                nvm_pkg::SEQ_LAUNCH: begin
                    if (op_is_real && !op_blocked) begin
                        array_cmd.start <= 1'b1;
                        array_cmd.op    <= op_reg;
                        array_cmd.addr  <= target_reg;
                        state_reg       <= nvm_pkg::SEQ_WAIT;
                    end else begin
                        go_reg    <= 1'b0;
                        state_reg <= nvm_pkg::SEQ_IDLE;
                    end
                end
                nvm_pkg::SEQ_WAIT: begin
                    if (array_done) begin
                        go_reg    <= 1'b0;
                        state_reg <= nvm_pkg::SEQ_IDLE;
                    end
                end
                default: begin
                    state_reg <= nvm_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Failure flag: result of the last program, erase or undefined-code sequence; cleared by an op code 0 start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fail_reg <= 1'b0;
        end else if (state_reg == nvm_pkg::SEQ_LAUNCH && !op_is_nop
                     && (!op_is_real || op_blocked)) begin
            fail_reg <= 1'b1;
        end else if (state_reg == nvm_pkg::SEQ_WAIT && array_done) begin
            fail_reg <= array_fail;
        end else if (clear_flags) begin
            fail_reg <= 1'b0;
        end
    end

    always_comb begin
        ctl_view = `ZERO32;
        ctl_view[`BIT_GO]        = go_reg;
        ctl_view[`BIT_ARM]       = arm_reg;
        ctl_view[`BIT_FAIL]      = fail_reg;
        ctl_view[`BIT_LV_ERR]    = low_volt_error;
        ctl_view[`BIT_LV_LIVE]   = low_volt_live;
        ctl_view[`OP_HI:`OP_LO]  = op_reg;
    end

    // Read data valid only in the cycle after the read strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `ZERO32;
        end else if (!req.rd) begin
            reg_rdata <= `ZERO32;
        end else if (req.addr == `OFS_CONTROL) begin
            reg_rdata <= ctl_view;
        end else if (req.addr == `OFS_TARGET) begin
            reg_rdata <= target_reg;
        end else begin
            reg_rdata <= `ZERO32;
        end
    end

    sequence go_write_s;
        ctl_wr && reg_wdata[`BIT_GO] && !go_reg;
    endsequence

    sequence launch_s;
        state_reg == nvm_pkg::SEQ_LAUNCH;
    endsequence

    go_needs_key_a: assert property (@(posedge ref_clk) disable iff (rst)
        go_write_s and !(arm_reg && unlocked) |=> !go_reg)
        else $error("go set without arm and unlock");

    go_starts_a: assert property (@(posedge ref_clk) disable iff (rst)
        go_write_s and arm_reg && unlocked |=> go_reg ##0 launch_s)
        else $error("accepted go did not start");

    go_ends_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == nvm_pkg::SEQ_WAIT && array_done |=> !go_reg)
        else $error("go not cleared at completion");

    arm_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        device_reset && !ctl_wr |=> !arm_reg && $stable(op_reg))
        else $error("device reset misbehaved");

    detector_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        !arm_reg |=> !low_volt_live)
        else $error("live bit with detector off");

    fail_result_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == nvm_pkg::SEQ_WAIT && array_done |=> fail_reg == $past(array_fail))
        else $error("fail flag wrong after completion");

    op_locked_a: assert property (@(posedge ref_clk) disable iff (rst)
        ctl_wr && arm_reg |=> $stable(op_reg))
        else $error("op select changed while armed");

    nop_no_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        launch_s and op_is_nop |=> !array_cmd.start && !go_reg)
        else $error("no-op started the array");

    protect_a: assert property (@(posedge ref_clk) disable iff (rst)
        launch_s and op_is_real && op_blocked |=> !array_cmd.start ##0 fail_reg)
        else $error("protected operation was started");

    zero_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd && reg_addr == `OFS_CONTROL |=> reg_rdata[31:16] == 16'h0000
        && reg_rdata[10:4] == 7'h00)
        else $error("unimplemented bits not zero");

    clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        launch_s and op_reg == `OP_NOP0 and !(go_reg && arm_reg && low_volt_sense)
        |=> !fail_reg && !low_volt_error)
        else $error("flags not cleared by no-op start");

    sequence real_launch_s;
        state_reg == nvm_pkg::SEQ_LAUNCH && op_is_real && !op_blocked;
    endsequence

    start_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
        real_launch_s |=> array_cmd.start && array_cmd.addr == $past(target_reg))
        else $error("start without latched target");

    target_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        go_reg |=> $stable(target_reg))
        else $error("target changed during operation");

    page_block_a: assert property (@(posedge ref_clk) disable iff (rst)
        launch_s and op_reg == `OP_PAGE_ERASE && page_protected |=> !array_cmd.start)
        else $error("protected page erase was started");

    row_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        launch_s and op_reg == `OP_ROW_PROG && !page_protected |=> array_cmd.start)
        else $error("row program not started");

    go_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == nvm_pkg::SEQ_WAIT && !array_done |=> go_reg)
        else $error("go dropped before completion");

    start_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        array_cmd.start |=> !array_cmd.start)
        else $error("start longer than one cycle");

    go_locked_a: assert property (@(posedge ref_clk) disable iff (rst)
        !arm_reg && !go_reg |=> !go_reg)
        else $error("go set while disarmed");

    lv_error_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        arm_reg && low_volt_sense && go_reg |=> low_volt_error)
        else $error("low-voltage error not set");

    lv_live_a: assert property (@(posedge ref_clk) disable iff (rst)
        arm_reg && low_volt_sense |=> low_volt_live)
        else $error("live bit missing during event");

    lv_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        !low_volt_sense |=> !low_volt_live)
        else $error("live bit without event");
endmodule : nvm_program_control

// file: hdl/unlock_detector.sv
// Two-write key sequence detector for the go bit.
// Assumes single-cycle write strobes from the register port.
`timescale 1ns/100ps
`include "nvm_defs.svh"

module unlock_detector (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        key_wr,
    input  wire logic [31:0] key_data,
    input  wire logic        other_wr,
    output logic             unlocked
);
    logic first_ok_reg;

    // Any write other than the second key or a repeat of the first key breaks the sequence
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_ok_reg <= 1'b0;
        end else if (key_wr) begin
            first_ok_reg <= (key_data == `UNLOCK_KEY_A);
        end else if (other_wr) begin
            first_ok_reg <= 1'b0;
        end
    end

    // Unlock lasts until the next write of any kind
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unlocked <= 1'b0;
        end else if (key_wr) begin
            unlocked <= first_ok_reg && (key_data == `UNLOCK_KEY_B);
        end else if (other_wr) begin
            unlocked <= 1'b0;
        end
    end
endmodule : unlock_detector

// file: test/nvm_program_control_bench.sv
// Self-checking bench for the program memory control block.
// Assumes nvm_defs.svh on the include path; the bench stands in for software and the array.
`timescale 1ns/100ps
`include "nvm_defs.svh"

module nvm_program_control_bench;
    logic                ref_clk;
    logic                rst;
    logic                device_reset;
    logic [7:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [31:0]         reg_rdata;
    nvm_pkg::array_cmd_s array_cmd;
    logic                array_done;
    logic                array_fail;
    logic                page_protected;
    logic                any_protected;
    logic                low_volt_sense;
    logic                detector_on;
    int                  miscompares;
    int                  checked;
    int                  cycles;
    int                  seed;
    logic [31:0]         exp_q[$];
    logic [31:0]         mask_q[$];
    logic [31:0]         addr_q[$];
    logic [3:0]          op_q[$];
    logic                rd_pend;
    logic                fail_val;
    logic                m_arm;
    logic                m_fail;
    logic                m_lve;
    logic [3:0]          m_op;

    nvm_program_control dut_u (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .device_reset   (device_reset),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .array_cmd      (array_cmd),
        .array_done     (array_done),
        .array_fail     (array_fail),
        .page_protected (page_protected),
        .any_protected  (any_protected),
        .low_volt_sense (low_volt_sense),
        .detector_on    (detector_on)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] ctl(input logic g, a, f, e, l, input logic [3:0] op);
        ctl = {16'h0000, g, a, f, e, l, 7'h00, op};
    endfunction : ctl

    task automatic print_verdict();
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        mask_q.push_back(m);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic rd_ctl(input logic [31:0] m);
        rd(`OFS_CONTROL, ctl(1'b0, m_arm, m_fail, m_lve, low_volt_sense & m_arm, m_op), m);
    endtask : rd_ctl

    // Full operation: load target, select code, arm, unlock, go, read go back for a started operation, then read result after 12 cycles
    task automatic run_op(input logic [3:0] op, input logic pp, input logic ap);
        logic [31:0] addr;
        logic        real_op;
        logic        blocked;
        int          r;
        addr = $random(seed);
        r = $random(seed);
        fail_val = r[0];
        real_op = (op == 4'h3 || op == 4'h4 || op == 4'h5);
        blocked = (op == 4'h5) ? ap : (real_op & pp);
        page_protected <= pp;
        any_protected <= ap;
        wr(`OFS_TARGET, addr);
        wr(`OFS_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, op));
        wr(`OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, op));
        m_op = op;
        m_arm = 1'b1;
        wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_A);
        wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_B);
        if (real_op && !blocked) begin
            op_q.push_back(op);
            addr_q.push_back(addr);
        end
        wr(`OFS_CONTROL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, op));
        if (real_op && !blocked) begin
            rd(`OFS_CONTROL, ctl(1'b1, 1'b1, 1'b0, 1'b0, low_volt_sense, op), 32'hFFFFCFFF);
        end
        repeat (12) @(posedge ref_clk);
        if (real_op && !blocked) m_fail = fail_val;
        else if (op > 4'h6 || blocked) m_fail = 1'b1;
        else if (op == 4'h0) m_fail = 1'b0;
        m_lve = low_volt_sense | (m_lve & (op != 4'h0));
        rd_ctl(32'hFFFFFFFF);
    endtask : run_op

    // Read data stand one cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_pend === 1'b1) begin
            chk(reg_rdata & mask_q[0], exp_q[0] & mask_q[0]);
            void'(exp_q.pop_front());
            void'(mask_q.pop_front());
        end
        rd_pend <= reg_rd;
    end

    // Array responder: checks each start, answers after a random delay
    initial begin
        array_done = 1'b0;
        array_fail = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (array_cmd.start === 1'b1) begin
                if (op_q.size() == 0) begin
                    chk(32'h1, 32'h0);
                end else begin
                    chk({28'h0, array_cmd.op}, {28'h0, op_q.pop_front()});
                    chk(array_cmd.addr, addr_q.pop_front());
                end
                repeat (3 + ($unsigned($random(seed)) % 4)) @(posedge ref_clk);
                array_done <= 1'b1;
                array_fail <= fail_val;
                @(posedge ref_clk);
                array_done <= 1'b0;
                array_fail <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        seed = 58;
        rst = 1'b1;
        device_reset = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_pend = 1'b0;
        page_protected = 1'b0;
        any_protected = 1'b0;
        low_volt_sense = 1'b0;
        fail_val = 1'b0;
        {m_arm, m_fail, m_lve, m_op} = 7'h00;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd_ctl(32'hFFFFFFFF);
        rd(`OFS_UNLOCK_KEY, 32'h00000000, 32'hFFFFFFFF);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h00000000, 32'hFFFFFFFF);
        wr(`OFS_CONTROL, 32'hFFFFBFFF);
        m_op = 4'hF;
        rd_ctl(32'hFFFFFFFF);
        wr(`OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0));
        m_arm = 1'b1;
        m_op = 4'h0;
        wr(`OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h5));
        rd_ctl(32'hFFFFFFFF);
        chk({31'h0, detector_on}, 32'h1);
        run_op(4'hF, 1'b0, 1'b0);
        run_op(4'h7, 1'b0, 1'b0);
        run_op(4'h3, 1'b0, 1'b0);
        run_op(4'h4, 1'b0, 1'b0);
        run_op(4'h5, 1'b0, 1'b0);
        run_op(4'h4, 1'b0, 1'b1);
        run_op(4'h3, 1'b1, 1'b0);
        run_op(4'h2, 1'b0, 1'b0);
        run_op(4'h6, 1'b0, 1'b0);
        run_op(4'h5, 1'b0, 1'b1);
        run_op(4'h0, 1'b0, 1'b0);
        low_volt_sense <= 1'b1;
        wr(`OFS_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, m_op));
        m_arm = 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_ctl(32'hFFFFFFFF);
        chk({31'h0, detector_on}, 32'h0);
        wr(`OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, m_op));
        m_arm = 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_ctl(32'hFFFFFFFF);
        run_op(4'h3, 1'b0, 1'b0);
        low_volt_sense <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_ctl(32'hFFFFFFFF);
        run_op(4'h0, 1'b0, 1'b0);
        run_op(4'h4, 1'b1, 1'b0);
        @(posedge ref_clk);
        device_reset <= 1'b1;
        @(posedge ref_clk);
        device_reset <= 1'b0;
        m_arm = 1'b0;
        rd_ctl(32'hFFFFFFFF);
        wr(`OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, m_op));
        m_arm = 1'b1;
        wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_A);
        wr(`OFS_TARGET, 32'h00000100);
        wr(`OFS_UNLOCK_KEY, `UNLOCK_KEY_B);
        wr(`OFS_CONTROL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, m_op));
        repeat (6) @(posedge ref_clk);
        rd_ctl(32'hFFFFFFFF);
        repeat (10) @(posedge ref_clk);
        print_verdict();
    end
endmodule : nvm_program_control_bench
